// File: logic/tcc_pkg.sv
package tcc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register port geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [3:0] OFS_CTRL1 = 4'h0;
  localparam logic [3:0] OFS_CTRL2 = 4'h1;
  localparam logic [3:0] OFS_STATUS = 4'h2;
  localparam logic [3:0] OFS_CAP1_HI = 4'h3;
  localparam logic [3:0] OFS_CAP1_LO = 4'h4;
  localparam logic [3:0] OFS_CAP2_HI = 4'h5;
  localparam logic [3:0] OFS_CAP2_LO = 4'h6;
  localparam logic [3:0] OFS_CMP1_HI = 4'h7;
  localparam logic [3:0] OFS_CMP1_LO = 4'h8;
  localparam logic [3:0] OFS_CMP2_HI = 4'h9;
  localparam logic [3:0] OFS_CMP2_LO = 4'hA;
  localparam logic [3:0] OFS_CNT_HI = 4'hB;
  localparam logic [3:0] OFS_CNT_LO = 4'hC;
  localparam logic [3:0] OFS_ALT_HI = 4'hD;
  localparam logic [3:0] OFS_ALT_LO = 4'hE;

  ////////////////////////////////////////////////////////////////////////////
  // Reset and reload values
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [15:0] CMP_RST = 16'h8000;
  localparam logic [15:0] CNT_RELOAD = 16'hFFFC;
  localparam logic [15:0] CNT_TOP = 16'hFFFF;
  localparam logic [15:0] OPM_CAPTURE = 16'hFFFD;
  localparam logic [15:0] CMP_LATE = 16'h0001;

  // Tick source encodings
  localparam logic [1:0] TICK_DIV4 = 2'h0;
  localparam logic [1:0] TICK_DIV2 = 2'h1;
  localparam logic [1:0] TICK_DIV8 = 2'h2;
  localparam logic [1:0] TICK_EXT = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // First control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic capture_irq_enable;
    logic compare_irq_enable;
    logic wrap_irq_enable;
    logic force_level_two;
    logic force_level_one;
    logic during_pulse_level;
    logic capture_edge_one;
    logic after_pulse_level;
  } tcc_ctrl1_s;

  // Second control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic compare_output_enable_one;
    logic compare_output_enable_two;
    logic one_pulse_enable;
    logic pwm_enable;
    logic [1:0] tick_source_select;
    logic capture_edge_two;
    logic ext_edge_rising;
  } tcc_ctrl2_s;

  // Status register layout, low three bits reserved
  typedef struct packed {
    logic capture_flag_one;
    logic compare_flag_one;
    logic counter_wrap_flag;
    logic capture_flag_two;
    logic compare_flag_two;
    logic [2:0] reserved;
  } tcc_status_s;

endpackage

// File: logic/tcc_timer.sv
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/1ns
// Operation
// RULE1: Active edge loads counter, sets capture flag
// RULE2: Capture interrupt needs enable and clear mask
// RULE3: Capture flag clears: status read, low access
// RULE4: High read locks capture until low read
// RULE5: Capture pins always feed capture logic
// RULE6: Capture and compare channels run independently
// RULE7: Compare match sets flag, drives level
// RULE8: Compare registers software only, reset 8000h
// RULE9: Compare flag clears: status read, low access
// RULE10: High write suspends compare until low
// RULE11: Output disabled keeps pin, flag still works
// RULE12: Match at value, or value plus one
// RULE13: Force copies level, no flag, no interrupt
// RULE14: Force ignored in pulse or PWM mode
// RULE15: One-pulse enable takes capture1 and compare1
// RULE16: Pulse trigger reloads counter, loads FFFDh
// RULE17: Compare one match ends the pulse
// RULE18: One-pulse never sets compare flag one
// RULE19: PWM wins when both modes enabled
// RULE20: Pulse or PWM: only capture two works
// RULE21: One-pulse: compare two flags, no waveform
// RULE22: Flash instance drops channel two flags
// RULE23: Counter reloads FFFCh on write, reset, trigger
// RULE24: Both select bits high pick external tick
// RULE25: Edge select bit picks capture transition
// RULE26: Capture pins synchronised, then edge detected
// RULE27: All updates on CPU clock, one interrupt
module tcc_timer #(
  parameter bit FLASH_TIMER = 1'b0
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // Register port
  input wire logic [tcc_pkg::ADDR_W-1:0] ADDR,
  input wire logic [tcc_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [tcc_pkg::DATA_W-1:0] RDATA,
  // Timer pins
  input wire logic CAPTURE_PIN_ONE,
  input wire logic CAPTURE_PIN_TWO,
  input wire logic EXT_CLK,
  output logic COMPARE_PIN_ONE,
  output logic COMPARE_PIN_TWO,
  output logic COMPARE_OE_ONE,
  output logic COMPARE_OE_TWO,
  // Interrupt
  input wire logic GLOBAL_MASK,
  output logic TIMER_IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // Control state
  tcc_pkg::tcc_ctrl1_s c1_ff, nxt_c1; // First control
  tcc_pkg::tcc_ctrl2_s c2_ff, nxt_c2; // Second control
  logic [7:0] rdata_ff, nxt_rdata; // Read return
  logic opm_on, pwm_on; // Effective modes
  logic div2_on; // Fastest prescale

  // Access decode strobes
  logic wr_c1, wr_c2, rd_sr;
  logic [1:0] acc_cap_l, rd_cap_h;
  logic [1:0] wr_cmp_h, wr_cmp_l, acc_cmp_l;
  logic acc_cnt_l, rd_cnt_h, wr_cnt_l;

  // Synchroniser chains, stage one read only by stage two
  logic [1:0] cap_s1_ff, cap_s2_ff, cap_s3_ff;
  logic ext_s1_ff, ext_s2_ff, ext_s3_ff;
  logic [1:0] cap_edge; // Qualified capture edges
  logic ext_edge; // Qualified external tick edge

  // Tick and counter
  logic [2:0] pre_ff, nxt_pre; // Prescaler
  logic tick, tick_d_ff; // Tick and its echo
  logic [15:0] cnt_ff, nxt_cnt; // Free-running counter
  logic [7:0] cnt_buf_ff, nxt_cnt_buf; // Buffered low byte
  logic cnt_lock_ff, nxt_cnt_lock; // High byte read pending
  logic wrap_ff, nxt_wrap, wrap_arm_ff, nxt_wrap_arm;
  logic opm_fire; // Pulse trigger

  // Capture channels
  logic [1:0][15:0] cap_ff, nxt_cap;
  logic [1:0] cap_flag_ff, nxt_cap_flag;
  logic [1:0] cap_lock_ff, nxt_cap_lock;
  logic [1:0] cap_arm_ff, nxt_cap_arm;

  // Compare channels
  logic [1:0][15:0] cmp_ff, nxt_cmp;
  logic [1:0] hold_ff, nxt_hold; // Compare suspended
  logic [1:0] cmp_flag_ff, nxt_cmp_flag;
  logic [1:0] cmp_arm_ff, nxt_cmp_arm;
  logic [1:0] pin_ff, nxt_pin; // Pin latches
  logic [1:0] hit; // Match this cycle

  tcc_pkg::tcc_status_s status; // Status view
  tcc_pkg::tcc_ctrl1_s wr_c1_val; // Incoming first control

  ////////////////////////////////////////////////////////////////////////////
  // Address decode, every strobe a single cycle
  always_comb begin
    wr_c1 = WR && (ADDR == tcc_pkg::OFS_CTRL1);
    wr_c2 = WR && (ADDR == tcc_pkg::OFS_CTRL2);
    rd_sr = RD && (ADDR == tcc_pkg::OFS_STATUS);
    acc_cap_l[0] = (RD || WR) && (ADDR == tcc_pkg::OFS_CAP1_LO);
    acc_cap_l[1] = (RD || WR) && (ADDR == tcc_pkg::OFS_CAP2_LO);
    rd_cap_h[0] = RD && (ADDR == tcc_pkg::OFS_CAP1_HI);
    rd_cap_h[1] = RD && (ADDR == tcc_pkg::OFS_CAP2_HI);
    wr_cmp_h[0] = WR && (ADDR == tcc_pkg::OFS_CMP1_HI);
    wr_cmp_h[1] = WR && (ADDR == tcc_pkg::OFS_CMP2_HI);
    wr_cmp_l[0] = WR && (ADDR == tcc_pkg::OFS_CMP1_LO);
    wr_cmp_l[1] = WR && (ADDR == tcc_pkg::OFS_CMP2_LO);
    acc_cmp_l[0] = (RD || WR) && (ADDR == tcc_pkg::OFS_CMP1_LO);
    acc_cmp_l[1] = (RD || WR) && (ADDR == tcc_pkg::OFS_CMP2_LO);
    // Only the main low byte clears the wrap flag
    acc_cnt_l = (RD || WR) && (ADDR == tcc_pkg::OFS_CNT_LO);
    wr_cnt_l = WR && ((ADDR == tcc_pkg::OFS_CNT_LO) ||
                      (ADDR == tcc_pkg::OFS_ALT_LO));
    rd_cnt_h = RD && ((ADDR == tcc_pkg::OFS_CNT_HI) ||
                      (ADDR == tcc_pkg::OFS_ALT_HI));
  end

  // Mode resolution
  always_comb begin
    pwm_on = c2_ff.pwm_enable;
    opm_on = c2_ff.one_pulse_enable && !c2_ff.pwm_enable; // [RULE19] [RULE15]
    div2_on = (c2_ff.tick_source_select == tcc_pkg::TICK_DIV2);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; pins always wired in, even when driven as outputs
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      cap_s1_ff <= 2'h0;
      cap_s2_ff <= 2'h0;
      cap_s3_ff <= 2'h0;
      ext_s1_ff <= 1'b0;
      ext_s2_ff <= 1'b0;
      ext_s3_ff <= 1'b0;
    end else begin
      cap_s1_ff <= {CAPTURE_PIN_TWO, CAPTURE_PIN_ONE}; // [RULE5] [RULE26]
      cap_s2_ff <= cap_s1_ff;
      cap_s3_ff <= cap_s2_ff;
      ext_s1_ff <= EXT_CLK;
      ext_s2_ff <= ext_s1_ff;
      ext_s3_ff <= ext_s2_ff;
    end
  end

  // Edge qualifiers look only at stages two and three
  always_comb begin
    cap_edge[0] = c1_ff.capture_edge_one ? // [RULE25] [RULE26]
                  (cap_s2_ff[0] && !cap_s3_ff[0]) :
                  (!cap_s2_ff[0] && cap_s3_ff[0]);
    cap_edge[1] = c2_ff.capture_edge_two ? // [RULE25]
                  (cap_s2_ff[1] && !cap_s3_ff[1]) :
                  (!cap_s2_ff[1] && cap_s3_ff[1]);
    ext_edge = c2_ff.ext_edge_rising ? (ext_s2_ff && !ext_s3_ff) :
               (!ext_s2_ff && ext_s3_ff);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tick select; external clock must run under a quarter of CLK
  always_comb begin
    nxt_pre = pre_ff + 3'h1;
    case (c2_ff.tick_source_select) // [RULE24]
      tcc_pkg::TICK_DIV2: tick = pre_ff[0];
      tcc_pkg::TICK_DIV4: tick = &pre_ff[1:0];
      tcc_pkg::TICK_DIV8: tick = &pre_ff;
      tcc_pkg::TICK_EXT: tick = ext_edge;
      default: tick = 1'b0;
    endcase
  end

  // Counter, wrap flag and 16-bit read buffer
  always_comb begin
    opm_fire = opm_on && cap_edge[0];
    nxt_cnt = cnt_ff;
    nxt_wrap = wrap_ff;
    nxt_wrap_arm = wrap_arm_ff;
    nxt_cnt_buf = cnt_buf_ff;
    nxt_cnt_lock = cnt_lock_ff;
    // Clear first so a same-cycle wrap still wins
    if (wrap_arm_ff && acc_cnt_l) begin
      nxt_wrap = 1'b0;
      nxt_wrap_arm = 1'b0;
    end else if (rd_sr && wrap_ff) begin
      nxt_wrap_arm = 1'b1;
    end
    if (wr_cnt_l || opm_fire) begin
      nxt_cnt = tcc_pkg::CNT_RELOAD; // [RULE23] [RULE16]
    end else if (tick) begin
      nxt_cnt = cnt_ff + 16'h0001;
      if (cnt_ff == tcc_pkg::CNT_TOP) begin
        nxt_wrap = 1'b1;
      end
    end
    // Low byte frozen from the first high read until a low read
    if (rd_cnt_h && !cnt_lock_ff) begin
      nxt_cnt_buf = cnt_ff[7:0];
      nxt_cnt_lock = 1'b1;
    end else if (RD && ((ADDR == tcc_pkg::OFS_CNT_LO) ||
                        (ADDR == tcc_pkg::OFS_ALT_LO))) begin
      nxt_cnt_lock = 1'b0;
    end
  end

  // Counter registers
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      pre_ff <= 3'h0;
      tick_d_ff <= 1'b0;
      cnt_ff <= tcc_pkg::CNT_RELOAD; // [RULE23]
      cnt_buf_ff <= 8'h00;
      cnt_lock_ff <= 1'b0;
      wrap_ff <= 1'b0;
      wrap_arm_ff <= 1'b0;
    end else begin
      pre_ff <= nxt_pre;
      tick_d_ff <= tick;
      cnt_ff <= nxt_cnt;
      cnt_buf_ff <= nxt_cnt_buf;
      cnt_lock_ff <= nxt_cnt_lock;
      wrap_ff <= nxt_wrap;
      wrap_arm_ff <= nxt_wrap_arm;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture channels, each with its own register and flag
  always_comb begin
    nxt_cap = cap_ff;
    nxt_cap_flag = cap_flag_ff;
    nxt_cap_lock = cap_lock_ff;
    nxt_cap_arm = cap_arm_ff;
    for (int i = 0; i < 2; i++) begin // [RULE6]
      // Clear path first; a same-cycle capture overrides it
      if (cap_arm_ff[i] && acc_cap_l[i]) begin // [RULE3]
        nxt_cap_flag[i] = 1'b0;
        nxt_cap_arm[i] = 1'b0;
      end else if (rd_sr && cap_flag_ff[i]) begin // [RULE3]
        nxt_cap_arm[i] = 1'b1;
      end
      if (rd_cap_h[i]) begin
        nxt_cap_lock[i] = 1'b1; // [RULE4]
      end else if (RD && acc_cap_l[i]) begin
        nxt_cap_lock[i] = 1'b0;
      end
    end
    // Channel one captures only outside pulse and PWM modes
    if (cap_edge[0] && !opm_on && !pwm_on && !cap_lock_ff[0]) begin
      nxt_cap[0] = cnt_ff; // [RULE1] [RULE4] [RULE20]
      nxt_cap_flag[0] = 1'b1;
    end else if (opm_fire) begin
      nxt_cap[0] = tcc_pkg::OPM_CAPTURE; // [RULE16]
      nxt_cap_flag[0] = 1'b1;
    end
    // Channel two absent on the flash instance
    if (cap_edge[1] && !cap_lock_ff[1] && !FLASH_TIMER) begin
      nxt_cap[1] = cnt_ff; // [RULE1] [RULE4] [RULE20]
      nxt_cap_flag[1] = 1'b1;
    end
    if (FLASH_TIMER) begin
      nxt_cap[1] = 16'h0000; // [RULE22]
      nxt_cap_flag[1] = 1'b0;
    end
  end

  // Capture registers
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      cap_ff <= '0;
      cap_flag_ff <= 2'h0;
      cap_lock_ff <= 2'h0;
      cap_arm_ff <= 2'h0;
    end else begin
      cap_ff <= nxt_cap;
      cap_flag_ff <= nxt_cap_flag;
      cap_lock_ff <= nxt_cap_lock;
      cap_arm_ff <= nxt_cap_arm;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare matches, checked once per count, one cycle after the tick
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      hit[i] = tick_d_ff && !hold_ff[i] && // [RULE10]
               (cnt_ff == (div2_on ? cmp_ff[i] : // [RULE12]
                           cmp_ff[i] + tcc_pkg::CMP_LATE));
    end
  end

  // Compare values, flags and pin latches
  always_comb begin
    wr_c1_val = tcc_pkg::tcc_ctrl1_s'(WDATA);
    nxt_cmp = cmp_ff;
    nxt_hold = hold_ff;
    nxt_cmp_flag = cmp_flag_ff;
    nxt_cmp_arm = cmp_arm_ff;
    nxt_pin = pin_ff;
    for (int i = 0; i < 2; i++) begin // [RULE6]
      // Only software writes touch the compare value
      if (wr_cmp_h[i]) begin
        nxt_cmp[i][15:8] = WDATA; // [RULE8]
        nxt_hold[i] = 1'b1; // [RULE10]
      end else if (wr_cmp_l[i]) begin
        nxt_cmp[i][7:0] = WDATA; // [RULE8]
        nxt_hold[i] = 1'b0; // [RULE10]
      end
      if (cmp_arm_ff[i] && acc_cmp_l[i]) begin // [RULE9]
        nxt_cmp_flag[i] = 1'b0;
        nxt_cmp_arm[i] = 1'b0;
      end else if (rd_sr && cmp_flag_ff[i]) begin // [RULE9]
        nxt_cmp_arm[i] = 1'b1;
      end
    end
    // Flags: none in PWM, none on channel one in pulse mode
    if (hit[0] && !pwm_on && !opm_on) begin
      nxt_cmp_flag[0] = 1'b1; // [RULE7] [RULE18]
    end
    if (hit[1] && !pwm_on && !FLASH_TIMER) begin
      nxt_cmp_flag[1] = 1'b1; // [RULE7] [RULE21]
    end
    // Pin one: match, pulse start or force, only when enabled
    if (c2_ff.compare_output_enable_one && !pwm_on) begin // [RULE11]
      if (opm_fire) begin
        nxt_pin[0] = c1_ff.during_pulse_level; // [RULE16]
      end else if (hit[0]) begin
        nxt_pin[0] = c1_ff.after_pulse_level; // [RULE7] [RULE17]
      end else if (wr_c1 && wr_c1_val.force_level_one && !opm_on) begin
        nxt_pin[0] = wr_c1_val.after_pulse_level; // [RULE13] [RULE14]
      end
    end
    // Pin two: its level bit belongs to the pulse in pulse mode
    if (c2_ff.compare_output_enable_two && !pwm_on && !opm_on) begin
      if (hit[1]) begin
        nxt_pin[1] = c1_ff.during_pulse_level; // [RULE7] [RULE21]
      end else if (wr_c1 && wr_c1_val.force_level_two) begin
        nxt_pin[1] = wr_c1_val.during_pulse_level; // [RULE13] [RULE14]
      end
    end
    if (FLASH_TIMER) begin
      nxt_cmp_flag[1] = 1'b0; // [RULE22]
    end
  end

  // Compare registers, pin latches low in reset
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      cmp_ff <= {tcc_pkg::CMP_RST, tcc_pkg::CMP_RST}; // [RULE8]
      hold_ff <= 2'h0;
      cmp_flag_ff <= 2'h0;
      cmp_arm_ff <= 2'h0;
      pin_ff <= 2'h0; // [RULE7]
    end else begin
      cmp_ff <= nxt_cmp;
      hold_ff <= nxt_hold;
      cmp_flag_ff <= nxt_cmp_flag;
      cmp_arm_ff <= nxt_cmp_arm;
      pin_ff <= nxt_pin;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control writes and read return
  always_comb begin
    status = '0;
    status.capture_flag_one = cap_flag_ff[0];
    status.compare_flag_one = cmp_flag_ff[0];
    status.counter_wrap_flag = wrap_ff;
    status.capture_flag_two = cap_flag_ff[1];
    status.compare_flag_two = cmp_flag_ff[1];
    nxt_c1 = c1_ff;
    nxt_c2 = c2_ff;
    if (wr_c1) begin
      // Force bits act on the write and are not kept
      nxt_c1 = tcc_pkg::tcc_ctrl1_s'(WDATA);
      nxt_c1.force_level_one = 1'b0;
      nxt_c1.force_level_two = 1'b0;
    end
    if (wr_c2) begin
      nxt_c2 = tcc_pkg::tcc_ctrl2_s'(WDATA);
    end
    nxt_rdata = 8'h00;
    if (RD) begin
      case (ADDR)
        tcc_pkg::OFS_CTRL1: nxt_rdata = c1_ff;
        tcc_pkg::OFS_CTRL2: nxt_rdata = c2_ff;
        tcc_pkg::OFS_STATUS: nxt_rdata = status;
        tcc_pkg::OFS_CAP1_HI: nxt_rdata = cap_ff[0][15:8];
        tcc_pkg::OFS_CAP1_LO: nxt_rdata = cap_ff[0][7:0];
        tcc_pkg::OFS_CAP2_HI: nxt_rdata = cap_ff[1][15:8];
        tcc_pkg::OFS_CAP2_LO: nxt_rdata = cap_ff[1][7:0];
        tcc_pkg::OFS_CMP1_HI: nxt_rdata = cmp_ff[0][15:8];
        tcc_pkg::OFS_CMP1_LO: nxt_rdata = cmp_ff[0][7:0];
        // Write-only on the flash instance
        tcc_pkg::OFS_CMP2_HI:
          nxt_rdata = FLASH_TIMER ? 8'h00 : cmp_ff[1][15:8]; // [RULE22]
        tcc_pkg::OFS_CMP2_LO:
          nxt_rdata = FLASH_TIMER ? 8'h00 : cmp_ff[1][7:0]; // [RULE22]
        tcc_pkg::OFS_CNT_HI, tcc_pkg::OFS_ALT_HI:
          nxt_rdata = cnt_ff[15:8];
        tcc_pkg::OFS_CNT_LO, tcc_pkg::OFS_ALT_LO:
          nxt_rdata = cnt_lock_ff ? cnt_buf_ff : cnt_ff[7:0];
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  // Control registers
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      c1_ff <= tcc_pkg::CTRL1_RST;
      c2_ff <= tcc_pkg::CTRL2_RST;
      rdata_ff <= 8'h00;
    end else begin
      c1_ff <= nxt_c1;
      c2_ff <= nxt_c2;
      rdata_ff <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; a pending flag raises the line once the mask opens
  always_comb begin
    RDATA = rdata_ff;
    COMPARE_PIN_ONE = pin_ff[0];
    COMPARE_PIN_TWO = pin_ff[1];
    COMPARE_OE_ONE = c2_ff.compare_output_enable_one;
    COMPARE_OE_TWO = c2_ff.compare_output_enable_two;
    TIMER_IRQ = !GLOBAL_MASK && // [RULE2] [RULE27]
                ((c1_ff.capture_irq_enable && |cap_flag_ff) ||
                 (c1_ff.compare_irq_enable && |cmp_flag_ff) ||
                 (c1_ff.wrap_irq_enable && wrap_ff));
  end

endmodule

// File: tb/tcc_props.sv
`timescale 1ns/1ns
// Port-level checks of the capture/compare timer
module tcc_props (
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // Register port
  input wire logic [tcc_pkg::ADDR_W-1:0] ADDR,
  input wire logic [tcc_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [tcc_pkg::DATA_W-1:0] RDATA,
  // Pins and interrupt
  input wire logic CAPTURE_PIN_TWO,
  input wire logic COMPARE_PIN_ONE,
  input wire logic COMPARE_PIN_TWO,
  input wire logic COMPARE_OE_ONE,
  input wire logic COMPARE_OE_TWO,
  input wire logic GLOBAL_MASK,
  input wire logic TIMER_IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  tcc_pkg::tcc_ctrl1_s ctrl1_ff, nxt_ctrl1; // Shadow of first control
  tcc_pkg::tcc_ctrl2_s ctrl2_ff, nxt_ctrl2; // Shadow of second control
  ////////////////////////////////////////////////////////////////////////////
  // Shadow of control writes, so no read-back is needed
  always_comb begin
    nxt_ctrl1 = ctrl1_ff;
    nxt_ctrl2 = ctrl2_ff;
    if (!NRST) begin
      nxt_ctrl1 = tcc_pkg::CTRL1_RST;
      nxt_ctrl2 = tcc_pkg::CTRL2_RST;
    end else if (WR && ADDR == tcc_pkg::OFS_CTRL1) begin
      nxt_ctrl1 = WDATA;
    end else if (WR && ADDR == tcc_pkg::OFS_CTRL2) begin
      nxt_ctrl2 = WDATA;
    end
  end
  // Registered only
  always_ff @(posedge CLK) begin
    ctrl1_ff <= nxt_ctrl1;
    ctrl2_ff <= nxt_ctrl2;
  end
  ////////////////////////////////////////////////////////////////////////////
  // First control write with force one set
  sequence s_force_one;
    WR && ADDR == tcc_pkg::OFS_CTRL1 && WDATA[3];
  endsequence
  // Rising capture on pin two, interrupt open
  sequence s_cap_two;
    $rose(CAPTURE_PIN_TWO) && ctrl2_ff.capture_edge_two &&
      ctrl1_ff.capture_irq_enable && !GLOBAL_MASK;
  endsequence
  a_reset_quiet: assert property (
    !$past(NRST) |-> RDATA == 8'h00 && !COMPARE_PIN_ONE && !COMPARE_PIN_TWO)
    else $error("outputs not quiet after reset");
  a_mask_irq: assert property (
    GLOBAL_MASK |-> !TIMER_IRQ) else $error("interrupt while masked");
  a_irq_cause: assert property (
    TIMER_IRQ |-> ctrl1_ff.capture_irq_enable ||
      ctrl1_ff.compare_irq_enable || ctrl1_ff.wrap_irq_enable)
    else $error("interrupt with no enable set");
  a_oe_mirror: assert property (
    COMPARE_OE_ONE == ctrl2_ff.compare_output_enable_one &&
      COMPARE_OE_TWO == ctrl2_ff.compare_output_enable_two)
    else $error("output enable differs from control");
  a_pin_kept: assert property (
    !COMPARE_OE_TWO && !$past(COMPARE_OE_TWO) |-> $stable(COMPARE_PIN_TWO))
    else $error("pin two moved while not owned");
  a_force_pin: assert property (
    s_force_one ##0 (COMPARE_OE_ONE && !ctrl2_ff.one_pulse_enable &&
      !ctrl2_ff.pwm_enable) |=> COMPARE_PIN_ONE == $past(WDATA[0]))
    else $error("forced level not on pin one");
  a_force_held: assert property (
    s_force_one ##0 (ctrl2_ff.one_pulse_enable || ctrl2_ff.pwm_enable)
      |=> $stable(COMPARE_PIN_ONE)) else $error("force acted in pulse mode");
  a_cap_irq: assert property (
    s_cap_two |-> ##[1:5] TIMER_IRQ)
    else $error("capture raised no interrupt");
endmodule

// File: tb/tcc_pins.sv
`timescale 1ns/1ns
// Drivers of the capture pins and the tick pin
module tcc_pins (
  // Pacing clock
  input wire logic clk,
  // Pins into the timer
  output logic cap_one,
  output logic cap_two,
  output logic ext_clk
);
  // Idle levels from time zero
  initial begin
    cap_one = 1'b0;
    cap_two = 1'b0;
    ext_clk = 1'b0;
  end
  // Free tick, well under a quarter of CLK
  always begin
    repeat (6) @(posedge clk);
    ext_clk <= ~ext_clk;
  end
  // Move one pin after a random delay of one to four cycles, then hold it
  task automatic drive(input int ch, input logic lvl);
    repeat ($urandom_range(4, 1)) @(posedge clk);
    if (ch == 1) begin
      cap_one <= lvl;
    end else begin
      cap_two <= lvl;
    end
    repeat (8) @(posedge clk); // Held past the sync stages
  endtask
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ns
module testbench;
  // Bench inputs, defined at time zero
  logic CLK = 1'b0, NRST = 1'b0, WR = 1'b0, RD = 1'b0, GLOBAL_MASK = 1'b0;
  logic [tcc_pkg::ADDR_W-1:0] ADDR = 4'h0;
  logic [tcc_pkg::DATA_W-1:0] WDATA = 8'h00;
  // Design outputs and partner pins
  logic [tcc_pkg::DATA_W-1:0] RDATA;
  logic CAPTURE_PIN_ONE, CAPTURE_PIN_TWO, EXT_CLK, TIMER_IRQ;
  logic COMPARE_PIN_ONE, COMPARE_PIN_TWO, COMPARE_OE_ONE, COMPARE_OE_TWO;
  logic [7:0] rd_val; // Last byte read
  logic [15:0] rnd; // Random compare value
  int n_fail = 0, tests_run = 0;
  int model_reg [16]; // Register model
  always #4 CLK = ~CLK;
  tcc_timer i_dut (.CLK, .NRST, .ADDR, .WDATA, .WR, .RD, .RDATA,
    .CAPTURE_PIN_ONE, .CAPTURE_PIN_TWO, .EXT_CLK, .COMPARE_PIN_ONE,
    .COMPARE_PIN_TWO, .COMPARE_OE_ONE, .COMPARE_OE_TWO, .GLOBAL_MASK,
    .TIMER_IRQ);
  tcc_pins i_pins (.clk(CLK), .cap_one(CAPTURE_PIN_ONE),
    .cap_two(CAPTURE_PIN_TWO), .ext_clk(EXT_CLK));
  ////////////////////////////////////////////////////////////////////////////
  // One comparison, counted
  task automatic chk(input string w, input logic [15:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic bit_chk(input string w, input logic e, input logic g);
    chk(w, {15'h0, e}, {15'h0, g});
  endtask
  // Write; returns once outputs settle, force bits read zero
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK);
    WR <= 1'b0;
    #1;
    if (a inside {[tcc_pkg::OFS_CTRL1:tcc_pkg::OFS_CTRL2],
        [tcc_pkg::OFS_CMP1_HI:tcc_pkg::OFS_CMP2_LO]}) begin
      model_reg[a] = (a == tcc_pkg::OFS_CTRL1) ? int'(d & 8'hE7) : int'(d);
    end
  endtask
  // Read; data stands only in the next cycle
  task automatic rd(input logic [3:0] a);
    @(posedge CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 1'b0;
    #1 rd_val = RDATA;
  endtask
  task automatic rdm(input logic [3:0] a);
    rd(a);
    chk("register", 16'(model_reg[a]), {8'h00, rd_val});
  endtask
  // Status with the wrap flag masked out
  task automatic st(input logic [7:0] e);
    rd(tcc_pkg::OFS_STATUS);
    chk("status", {8'h00, e}, {8'h00, rd_val & 8'hDF});
  endtask
  // Bounded wait for pin one (0) or the interrupt (1)
  task automatic wait_sig(input int s, input logic lvl, input int lim);
    int k;
    k = 0;
    while ((s == 0 ? COMPARE_PIN_ONE : TIMER_IRQ) !== lvl && k < lim) begin
      @(posedge CLK);
      #1 k++;
    end
    bit_chk("waited signal", lvl, s == 0 ? COMPARE_PIN_ONE : TIMER_IRQ);
  endtask
  task automatic done(input string n);
    $display("test %s finished", n);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rnd = 16'($urandom(32'hBBEA));
    foreach (model_reg[i]) model_reg[i] = 0;
    model_reg[tcc_pkg::OFS_CMP1_HI] = 8'h80;
    model_reg[tcc_pkg::OFS_CMP2_HI] = 8'h80;
    repeat (2) @(posedge CLK);
    NRST <= 1'b1;
    foreach (model_reg[i]) begin
      if (!(i inside {[3:6], [11:14]})) begin
        rdm(4'(i));
      end
    end
    done("reset values");
    rnd = 16'($urandom);
    wr(tcc_pkg::OFS_CMP2_HI, rnd[15:8]);
    wr(tcc_pkg::OFS_CMP2_LO, rnd[7:0]);
    rdm(tcc_pkg::OFS_CMP2_HI);
    rdm(tcc_pkg::OFS_CMP2_LO);
    done("compare read back");
    // Channel one suspended, channel two matches, pin two free
    wr(tcc_pkg::OFS_CTRL1, 8'h41);
    wr(tcc_pkg::OFS_CTRL2, 8'h84);
    wr(tcc_pkg::OFS_CMP1_HI, 8'h00);
    wr(tcc_pkg::OFS_CMP2_HI, 8'h00);
    wr(tcc_pkg::OFS_CMP2_LO, 8'h08);
    wr(tcc_pkg::OFS_CNT_LO, 8'h00);
    repeat (60) @(posedge CLK);
    st(8'h08);
    bit_chk("pin one", 1'b0, COMPARE_PIN_ONE);
    bit_chk("pin two", 1'b0, COMPARE_PIN_TWO);
    bit_chk("irq", 1'b1, TIMER_IRQ);
    wr(tcc_pkg::OFS_CMP1_LO, 8'h10);
    wr(tcc_pkg::OFS_CMP2_LO, 8'h08);
    st(8'h00);
    wr(tcc_pkg::OFS_CNT_LO, 8'h00);
    wait_sig(0, 1'b1, 100);
    st(8'h48);
    done("compare match");
    wr(tcc_pkg::OFS_CMP1_LO, 8'h10);
    wr(tcc_pkg::OFS_CMP2_LO, 8'h08);
    wr(tcc_pkg::OFS_CTRL1, 8'h48);
    bit_chk("pin one", 1'b0, COMPARE_PIN_ONE);
    st(8'h00);
    done("forced level");
    // Capture on pin two: masked, pending, cleared, locked
    wr(tcc_pkg::OFS_CTRL1, 8'h80);
    wr(tcc_pkg::OFS_CTRL2, 8'h06);
    GLOBAL_MASK <= 1'b1;
    i_pins.drive(2, 1'b1);
    bit_chk("irq", 1'b0, TIMER_IRQ);
    st(8'h10);
    GLOBAL_MASK <= 1'b0;
    wait_sig(1, 1'b1, 2);
    rd(tcc_pkg::OFS_CAP2_HI);
    rd(tcc_pkg::OFS_CAP2_LO);
    st(8'h00);
    GLOBAL_MASK <= 1'b1;
    rd(tcc_pkg::OFS_CAP2_HI);
    i_pins.drive(2, 1'b0);
    i_pins.drive(2, 1'b1);
    st(8'h00);
    rd(tcc_pkg::OFS_CAP2_LO);
    GLOBAL_MASK <= 1'b0;
    i_pins.drive(2, 1'b0);
    i_pins.drive(2, 1'b1);
    st(8'h10);
    rd(tcc_pkg::OFS_CAP2_LO);
    done("capture");
    // One pulse: force ignored, trigger, end on compare one
    wr(tcc_pkg::OFS_CTRL2, 8'hA4);
    wr(tcc_pkg::OFS_CTRL1, 8'h8F);
    bit_chk("pin one", 1'b0, COMPARE_PIN_ONE);
    wr(tcc_pkg::OFS_CTRL1, 8'h86);
    wr(tcc_pkg::OFS_CMP1_HI, 8'h00);
    wr(tcc_pkg::OFS_CMP1_LO, 8'h20);
    i_pins.drive(1, 1'b1);
    bit_chk("pin one", 1'b1, COMPARE_PIN_ONE);
    rd(tcc_pkg::OFS_CAP1_HI);
    chk("capture high", 16'h00FF, {8'h00, rd_val});
    rd(tcc_pkg::OFS_CAP1_LO);
    chk("capture low", 16'h00FD, {8'h00, rd_val});
    wait_sig(0, 1'b0, 200);
    st(8'h88);
    bit_chk("pin two", 1'b0, COMPARE_PIN_TWO);
    done("one pulse");
    tally_and_finish();
  end
  // Watchdog, far beyond the run length
  initial begin
    #100000;
    n_fail++;
    tally_and_finish();
  end
endmodule
bind tcc_timer tcc_props i_props (.CLK, .NRST, .ADDR, .WDATA, .WR, .RD,
  .RDATA, .CAPTURE_PIN_TWO, .COMPARE_PIN_ONE, .COMPARE_PIN_TWO,
  .COMPARE_OE_ONE, .COMPARE_OE_TWO, .GLOBAL_MASK, .TIMER_IRQ);
